// ===== bapt_asserts.sv
// Checker of link clock shape and command spacing on the controller-to-device link.
`timescale 1ns/1ps
module bapt_asserts
  import bapt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ck,
  input wire logic [2:0] cmd,
  input wire logic [2:0] bank,
  input wire logic ap,
  input wire logic all_banks,
  input wire logic bl32
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  logic ck_reg, rise, is_col, rap_on_reg, wap_on_reg, rap_bl_reg, wap_bl_reg;
  logic [7:0] act_gap_reg [NUM_BANKS];
  logic [7:0] rap_gap_reg, wap_gap_reg;
  logic [2:0] rap_bank_reg, wap_bank_reg;
  logic [NUM_BANKS-1:0] shut_reg;
  // A link clock rise is where commands are taken.
  assign rise = ck && !ck_reg;
  assign is_col = (cmd == BAPT_CMD_RD) || (cmd == BAPT_CMD_WR) || (cmd == BAPT_CMD_MWR);
  // Counts rises since each activate and since the last auto-precharge columns.
  always_ff @(posedge clk_sys_i) begin
    ck_reg <= ck;
    if (srst_i) begin
      shut_reg <= '0;
      rap_on_reg <= 1'b0;
      wap_on_reg <= 1'b0;
      for (int i = 0; i < NUM_BANKS; i++) act_gap_reg[i] <= 8'hff;
    end else if (rise) begin
      for (int i = 0; i < NUM_BANKS; i++) if (act_gap_reg[i] != 8'hff) act_gap_reg[i] <= act_gap_reg[i] + 8'h01;
      if (rap_gap_reg != 8'hff) rap_gap_reg <= rap_gap_reg + 8'h01;
      if (wap_gap_reg != 8'hff) wap_gap_reg <= wap_gap_reg + 8'h01;
      if (cmd == BAPT_CMD_ACT) begin
        act_gap_reg[bank] <= 8'h00;
        shut_reg[bank] <= 1'b0;
      end
      if (is_col && ap) shut_reg[bank] <= 1'b1;
      if (cmd == BAPT_CMD_RD && ap) begin
        {rap_on_reg, rap_gap_reg, rap_bank_reg, rap_bl_reg} <= {1'b1, 8'h00, bank, bl32};
      end
      if ((cmd == BAPT_CMD_WR || cmd == BAPT_CMD_MWR) && ap) begin
        {wap_on_reg, wap_gap_reg, wap_bank_reg, wap_bl_reg} <= {1'b1, 8'h00, bank, bl32};
      end
    end
  end
  sequence high_run;
    ck [*8] ##1 !ck;
  endsequence
  sequence low_run;
    !ck [*8] ##1 ck;
  endsequence
  AST_CK_HIGH: assert property ($rose(ck) |-> high_run) else $error("link clock high time wrong");
  AST_CK_LOW: assert property ($fell(ck) |-> low_run) else $error("link clock low time wrong");
  AST_FIELDS_HOLD: assert property (
    ck && ck_reg |-> $stable({cmd, bank, ap, all_banks, bl32}))
    else $error("link fields moved while clock high");
  AST_TRCD: assert property (rise && is_col |-> act_gap_reg[bank] + 1 >= T_RCD_NCK)
    else $error("column too soon after activate");
  AST_TRC: assert property (
    rise && cmd == BAPT_CMD_ACT |-> act_gap_reg[bank] + 1 >= T_RC_NCK)
    else $error("activate too soon after activate");
  AST_NO_COL_AFTER_AP: assert property (rise && is_col |-> !shut_reg[bank])
    else $error("column to bank closed by auto-precharge");
  AST_RAP_RD: assert property (
    rise && cmd == BAPT_CMD_RD && rap_on_reg && bank != rap_bank_reg
    |-> rap_gap_reg + 1 >= (rap_bl_reg ? 16 : 8)) else $error("read after read ap too soon");
  AST_RAP_WR: assert property (
    rise && (cmd == BAPT_CMD_WR || cmd == BAPT_CMD_MWR) && rap_on_reg
    && bank != rap_bank_reg |-> rap_gap_reg + 1 >= RL_NCK + T_DQSCK_NCK + (rap_bl_reg ? 16 : 8)
    + T_RPST_NCK - WL_NCK + T_WPRE_NCK) else $error("write after read ap too soon");
  AST_WAP_WR: assert property (
    rise && (cmd == BAPT_CMD_WR || cmd == BAPT_CMD_MWR) && wap_on_reg
    && bank != wap_bank_reg |-> wap_gap_reg + 1 >= (wap_bl_reg ? 16 : 8))
    else $error("write after write ap too soon");
  AST_WAP_RD: assert property (
    rise && cmd == BAPT_CMD_RD && wap_on_reg && bank != wap_bank_reg
    |-> wap_gap_reg + 1 >= WL_NCK + (wap_bl_reg ? 16 : 8) + T_WTR_NCK + 1)
    else $error("read after write ap too soon");
endmodule : bapt_asserts

// ===== bapt_bank.sv
// One bank: open state, RAS lockout and the pending auto-precharge countdown.
`timescale 1ns/1ps
module bapt_bank
  import bapt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic tick_i,
  input wire logic act_i,
  input wire logic pre_i,
  input wire logic ap_i,
  input wire logic [CNT_W-1:0] ap_delay_i,
  output logic open_o,
  output logic ap_start_o
);
  logic open_reg, open_next;
  logic pend_reg, pend_next;
  logic [CNT_W-1:0] dly_reg, dly_next;
  logic [CNT_W-1:0] ras_reg, ras_next;
  logic start_reg, start_next;

  // Next state for the bank timers, evaluated on link clock ticks.
  always_comb begin
    open_next = open_reg;
    pend_next = pend_reg;
    dly_next = dly_reg;
    ras_next = ras_reg;
    start_next = 1'b0;
    if (tick_i) begin
      if (ras_reg != '0) begin
        ras_next = ras_reg - 1'b1;
      end
      if (pend_reg && dly_reg != '0) begin
        dly_next = dly_reg - 1'b1;
      end
      if (pend_reg && dly_reg <= 8'h01 && ras_reg <= 8'h01) begin
        pend_next = 1'b0;
        open_next = 1'b0;
        start_next = 1'b1;
      end
      if (act_i) begin
        open_next = 1'b1;
        ras_next = CNT_W'(T_RAS_NCK);
      end
      if (pre_i) begin
        open_next = 1'b0;
      end
      if (ap_i && open_reg) begin
        pend_next = 1'b1;
        dly_next = ap_delay_i;
      end
    end
  end

  // Registers of the bank.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      open_reg <= 1'b0;
      pend_reg <= 1'b0;
      dly_reg <= '0;
      ras_reg <= '0;
      start_reg <= 1'b0;
    end else begin
      open_reg <= open_next;
      pend_reg <= pend_next;
      dly_reg <= dly_next;
      ras_reg <= ras_next;
      start_reg <= start_next;
    end
  end

  assign open_o = open_reg;
  assign ap_start_o = start_reg;
endmodule : bapt_bank

// ===== bapt_bench.sv
// Self-checking bench joining the controller end and the device end over the link.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module bapt_bench;
  import bapt_pkg::*;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic req_valid, req_ap, req_all, req_bl32, req_done, req_ready, ck_q, ok;
  logic all_sel = 1'b0;
  logic [2:0] req_cmd, req_bank;
  logic [CNT_W-1:0] nwr = NWR_RESET;
  logic [CNT_W-1:0] nrtp = NRTP_RESET;
  logic [NUM_BANKS-1:0] bank_open, ap_start;
  int n_fail = 0;
  int tests_run = 0;
  int tick = 0;
  int cycles = 0;
  int old_act;
  int act_t[NUM_BANKS], col_t[NUM_BANKS], ap_t[NUM_BANKS], ap_n[NUM_BANKS];
  bapt_link_if link();
  bapt_ctrl i_bapt_ctrl (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .link(link), .req_valid_i(req_valid),
    .req_cmd_i(req_cmd), .req_bank_i(req_bank), .req_ap_i(req_ap), .req_all_i(req_all),
    .req_bl32_i(req_bl32), .nwr_i(nwr), .nrtp_i(nrtp), .req_ready_o(req_ready),
    .req_done_o(req_done));
  bapt_dev i_bapt_dev (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .link(link), .nwr_i(nwr),
    .nrtp_i(nrtp), .bank_open_o(bank_open), .ap_start_o(ap_start));
  bapt_asserts i_bapt_asserts (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ck(link.ck), .cmd(link.cmd),
    .bank(link.bank), .ap(link.ap), .all_banks(link.all_banks), .bl32(link.bl32));
  // System clock of 8 ns.
  always #4 clk_sys_i = ~clk_sys_i;
  // Stamps link clock rises carrying commands, auto-precharge starts, and cuts a hang short.
  always @(posedge clk_sys_i) begin
    cycles++;
    ck_q <= link.ck;
    if (link.ck === 1'b1 && ck_q === 1'b0) begin
      tick++;
      if (link.cmd == BAPT_CMD_ACT) act_t[link.bank] = tick;
      if (link.cmd inside {BAPT_CMD_RD, BAPT_CMD_WR, BAPT_CMD_MWR}) col_t[link.bank] = tick;
    end
    for (int b = 0; b < NUM_BANKS; b++) if (ap_start[b] === 1'b1) begin
      ap_t[b] = tick;
      ap_n[b]++;
    end
    if (cycles == 60000) begin
      n_fail++;
      complete_run();
    end
  end
  // Holds one request until the controller reports it issued, or gives up after lim cycles.
  task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic a, input logic l,
      input int lim, output logic done);
    @(negedge clk_sys_i);
    {req_valid, req_cmd, req_bank, req_ap, req_all, req_bl32} = {1'b1, c, b, a, all_sel, l};
    done = 1'b0;
    for (int i = 0; i < lim && !done; i++) begin
      @(posedge clk_sys_i);
      #1 done = (req_done === 1'b1);
    end
    if (done) `CHK(req_ready, 1'b1)
    @(negedge clk_sys_i);
    req_valid = 1'b0;
  endtask : issue
  // Opens a bank, sends one auto-precharge column and checks when the bank closes.
  task automatic ap_case(input logic [2:0] b, input logic [2:0] c, input logic l, input int d);
    int exp;
    issue(BAPT_CMD_ACT, b, 1'b0, 1'b0, 400, ok);
    issue(c, b, 1'b1, l, 400, ok);
    repeat (d * 16 + 240) @(posedge clk_sys_i);
    exp = (col_t[b] - act_t[b] + d > T_RAS_NCK) ? col_t[b] - act_t[b] + d : T_RAS_NCK;
    `CHK(ap_t[b] - act_t[b], exp)
    `CHK(ap_n[b], 1)
    `CHK(bank_open[b], 1'b0)
    $display("auto-precharge case on bank %0d ended", b);
  endtask : ap_case
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // Main sequence: reset, auto-precharge cases, open-bank case, refusals, reactivation.
  initial begin
    {req_valid, req_cmd, req_bank, req_ap, req_all, req_bl32, ck_q} = '0;
    repeat (16) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    srst_i = 1'b0;
    ap_case(3'h0, BAPT_CMD_RD, 1'b0, int'(nrtp));
    ap_case(3'h1, BAPT_CMD_WR, 1'b0, WL_NCK + BL16 / 2 + 1 + int'(nwr));
    ap_case(3'h4, BAPT_CMD_MWR, 1'b0, WL_NCK + BL16 / 2 + 1 + int'(nwr));
    ap_case(3'h2, BAPT_CMD_RD, 1'b1, BL32_EXTRA_NCK + int'(nrtp));
    @(negedge clk_sys_i);
    nwr = 8'h03;
    nrtp = 8'h06;
    ap_case(3'h5, BAPT_CMD_WR, 1'b1, WL_NCK + BL32 / 2 + 1 + int'(nwr));
    ap_case(3'h6, BAPT_CMD_RD, 1'b0, int'(nrtp));
    issue(BAPT_CMD_ACT, 3'h3, 1'b0, 1'b0, 400, ok);
    issue(BAPT_CMD_RD, 3'h3, 1'b0, 1'b0, 400, ok);
    repeat (600) @(posedge clk_sys_i);
    `CHK(bank_open[3], 1'b1)
    `CHK(ap_n[3], 0)
    issue(BAPT_CMD_PRE, 3'h3, 1'b0, 1'b0, 400, ok);
    repeat (100) @(posedge clk_sys_i);
    `CHK(bank_open[3], 1'b0)
    $display("open bank case ended");
    issue(BAPT_CMD_RD, 3'h0, 1'b0, 1'b0, 100, ok);
    `CHK(ok, 1'b0)
    issue(BAPT_CMD_WR, 3'h1, 1'b0, 1'b0, 100, ok);
    `CHK(ok, 1'b0)
    $display("refusal case ended");
    old_act = act_t[0];
    issue(BAPT_CMD_ACT, 3'h0, 1'b0, 1'b0, 400, ok);
    repeat (40) @(posedge clk_sys_i);
    `CHK(act_t[0] - ap_t[0] >= T_RPPB_NCK, 1'b1)
    `CHK(act_t[0] - old_act >= T_RC_NCK, 1'b1)
    `CHK(bank_open[0], 1'b1)
    $display("reactivation case ended");
    all_sel = 1'b1;
    issue(BAPT_CMD_PRE, 3'h7, 1'b0, 1'b0, 400, ok);
    all_sel = 1'b0;
    repeat (100) @(posedge clk_sys_i);
    `CHK(ok, 1'b1)
    `CHK(bank_open, 8'h00)
    $display("precharge all case ended");
    complete_run();
  end
endmodule : bapt_bench

// ===== bapt_ctrl.sv
// Controller end: drives the link clock and issues commands with legal spacing.
`timescale 1ns/1ps
module bapt_ctrl
  import bapt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  bapt_link_if.ctrl link,
  input wire logic req_valid_i,
  input wire logic [2:0] req_cmd_i,
  input wire logic [2:0] req_bank_i,
  input wire logic req_ap_i,
  input wire logic req_all_i,
  input wire logic req_bl32_i,
  input wire logic [CNT_W-1:0] nwr_i,
  input wire logic [CNT_W-1:0] nrtp_i,
  output logic req_ready_o,
  output logic req_done_o
);
  localparam logic [CNT_W-1:0] BL16H = CNT_W'(BL16 / 2);
  logic [3:0] div_reg, div_next;
  logic ck_reg, ck_next;
  logic fall;
  logic [CNT_W-1:0] act_w_reg [NUM_BANKS], act_w_next [NUM_BANKS];
  logic [CNT_W-1:0] col_w_reg [NUM_BANKS], col_w_next [NUM_BANKS];
  logic [CNT_W-1:0] pre_w_reg [NUM_BANKS], pre_w_next [NUM_BANKS];
  logic [CNT_W-1:0] rd_w_reg, rd_w_next, wr_w_reg, wr_w_next;
  logic [2:0] cmd_reg, cmd_next, bank_reg, bank_next;
  logic ap_reg, ap_next, all_reg, all_next, bl_reg, bl_next, done_reg, done_next;
  logic ok;
  logic [CNT_W-1:0] bh;
  logic [CNT_W-1:0] wrdone;
  logic [CNT_W-1:0] gap;

  // Link clock divider; commands change on the falling edge.
  always_comb begin
    div_next = div_reg + 4'h1;
    ck_next = ck_reg;
    if (div_reg == 4'(LINK_HALF_DIV - 1)) begin
      div_next = '0;
      ck_next = ~ck_reg;
    end
  end
  assign fall = (div_reg == 4'(LINK_HALF_DIV - 1)) && ck_reg;

  always_comb begin
    ok = 1'b1;
    case (bapt_cmd_t'(req_cmd_i))
      BAPT_CMD_ACT: ok = act_w_reg[req_bank_i] == '0;
      BAPT_CMD_RD: ok = col_w_reg[req_bank_i] == '0 && rd_w_reg == '0;
      BAPT_CMD_WR, BAPT_CMD_MWR: ok = col_w_reg[req_bank_i] == '0 && wr_w_reg == '0;
      BAPT_CMD_PRE: begin
        ok = pre_w_reg[req_bank_i] == '0;
        if (req_all_i) begin
          for (int i = 0; i < NUM_BANKS; i++) begin
            ok = ok && pre_w_reg[i] == '0;
          end
        end
      end
      default: ok = 1'b1;
    endcase
  end

  // Command issue and per-bank wait counters, stepped on link clock falls.
  always_comb begin
    bh = req_bl32_i ? CNT_W'(BL32 / 2) : BL16H;
    wrdone = CNT_W'(CNT_W'(WL_NCK) + bh + 8'h01);
    gap = '0;
    rd_w_next = rd_w_reg;
    wr_w_next = wr_w_reg;
    cmd_next = cmd_reg;
    bank_next = bank_reg;
    ap_next = ap_reg;
    all_next = all_reg;
    bl_next = bl_reg;
    done_next = 1'b0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      act_w_next[i] = act_w_reg[i];
      col_w_next[i] = col_w_reg[i];
      pre_w_next[i] = pre_w_reg[i];
    end
    if (fall) begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        if (act_w_next[i] != '0) act_w_next[i] = act_w_next[i] - 1'b1;
        // All ones marks a bank closed to columns until its next activate.
        if (col_w_next[i] != '0 && col_w_next[i] != '1) col_w_next[i] = col_w_next[i] - 1'b1;
        if (pre_w_next[i] != '0) pre_w_next[i] = pre_w_next[i] - 1'b1;
      end
      if (rd_w_next != '0) rd_w_next = rd_w_next - 1'b1;
      if (wr_w_next != '0) wr_w_next = wr_w_next - 1'b1;
      cmd_next = 3'(BAPT_CMD_NOP);
      if (req_valid_i && ok) begin
        cmd_next = req_cmd_i;
        bank_next = req_bank_i;
        ap_next = req_ap_i;
        all_next = req_all_i;
        bl_next = req_bl32_i;
        done_next = 1'b1;
        case (bapt_cmd_t'(req_cmd_i))
          BAPT_CMD_ACT: begin
            act_w_next[req_bank_i] = CNT_W'(T_RC_NCK);
            col_w_next[req_bank_i] = CNT_W'(T_RCD_NCK);
            pre_w_next[req_bank_i] = CNT_W'(T_RAS_NCK);
          end
          BAPT_CMD_RD: begin
            rd_w_next = bh;
            wr_w_next = CNT_W'(CNT_W'(RL_NCK + T_DQSCK_NCK + T_RPST_NCK + T_WPRE_NCK)
                        + bh - CNT_W'(WL_NCK));
            if (req_ap_i) begin
              pre_w_next[req_bank_i] = CNT_W'(nrtp_i + (req_bl32_i ? 8'h08 : 8'h00));
              gap = CNT_W'(pre_w_next[req_bank_i] + CNT_W'(T_RPPB_NCK));
              if (gap > act_w_next[req_bank_i]) act_w_next[req_bank_i] = gap;
              col_w_next[req_bank_i] = 8'hff;
            end else begin
              gap = CNT_W'(T_RTP_NCK + (req_bl32_i ? BL32_EXTRA_NCK : 0));
              // Precharge must also wait out the row active time since activate.
              if (gap > pre_w_next[req_bank_i]) pre_w_next[req_bank_i] = gap;
            end
          end
          BAPT_CMD_WR, BAPT_CMD_MWR: begin
            wr_w_next = bh;
            rd_w_next = CNT_W'(wrdone + CNT_W'(T_WTR_NCK));
            if (req_ap_i) begin
              pre_w_next[req_bank_i] = CNT_W'(wrdone + nwr_i);
              gap = CNT_W'(wrdone + nwr_i + CNT_W'(T_RPPB_NCK));
              if (gap > act_w_next[req_bank_i]) act_w_next[req_bank_i] = gap;
              col_w_next[req_bank_i] = 8'hff;
            end else begin
              pre_w_next[req_bank_i] = CNT_W'(wrdone + nwr_i);
            end
          end
          BAPT_CMD_PRE: begin
            for (int i = 0; i < NUM_BANKS; i++) begin
              if (req_all_i || req_bank_i == 3'(i)) begin
                if (act_w_next[i] < CNT_W'(T_RPPB_NCK)) act_w_next[i] = CNT_W'(T_RPPB_NCK);
                col_w_next[i] = 8'hff;
              end
            end
          end
          default: done_next = 1'b1;
        endcase
        // Reactivation reopens columns after tRCD.
        if (bapt_cmd_t'(req_cmd_i) == BAPT_CMD_ACT) col_w_next[req_bank_i] = CNT_W'(T_RCD_NCK);
      end
    end
  end

  // Registers of the controller end.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      div_reg <= '0;
      ck_reg <= 1'b0;
      rd_w_reg <= '0;
      wr_w_reg <= '0;
      cmd_reg <= '0;
      bank_reg <= '0;
      ap_reg <= 1'b0;
      all_reg <= 1'b0;
      bl_reg <= 1'b0;
      done_reg <= 1'b0;
      for (int i = 0; i < NUM_BANKS; i++) begin
        act_w_reg[i] <= '0;
        col_w_reg[i] <= 8'hff;
        pre_w_reg[i] <= '0;
      end
    end else begin
      div_reg <= div_next;
      ck_reg <= ck_next;
      rd_w_reg <= rd_w_next;
      wr_w_reg <= wr_w_next;
      cmd_reg <= cmd_next;
      bank_reg <= bank_next;
      ap_reg <= ap_next;
      all_reg <= all_next;
      bl_reg <= bl_next;
      done_reg <= done_next;
      act_w_reg <= act_w_next;
      col_w_reg <= col_w_next;
      pre_w_reg <= pre_w_next;
    end
  end

  assign link.ck = ck_reg;
  assign link.cmd = cmd_reg;
  assign link.bank = bank_reg;
  assign link.ap = ap_reg;
  assign link.all_banks = all_reg;
  assign link.bl32 = bl_reg;
  assign req_ready_o = done_reg;
  assign req_done_o = done_reg;
endmodule : bapt_ctrl

// ===== bapt_dev.sv
// Device end: samples the link and runs eight independent bank timers.
// Behaviour
// - Write AP precharges tWR after burst end
// - Activate after AP waits tRPpb
// - AP bit closes bank automatically
// - AP low leaves bank open
// - Column with AP only after tRCD
// - AP precharge deferred until tRAS met
// - Same-bank activate waits tRC
// - Write then read AP respects tWR; read waits only tWTR after the burst, so tWR holds while nWR <= tWTR + nRTP
// - Read to precharge waits tRTP
// - No column to bank after read AP
// - Read AP to other-bank write spacing
// - Read AP to other-bank read BL/2
// - No column to bank after write AP
// - Write AP to other-bank write BL/2
// - Write AP to read WL+BL/2+tWTR+1
// - Read AP starts nRTP (+8 BL32)
// - nWR and nRTP from mode fields
// - No command shorter than minimum spacing
`timescale 1ns/1ps
module bapt_dev
  import bapt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  bapt_link_if.dev link,
  input wire logic [CNT_W-1:0] nwr_i,
  input wire logic [CNT_W-1:0] nrtp_i,
  output logic [NUM_BANKS-1:0] bank_open_o,
  output logic [NUM_BANKS-1:0] ap_start_o
);
  logic [2:0] ck_sync_reg;
  logic [2:0] cmd_s1_reg, cmd_s2_reg;
  logic [5:0] ctl_s1_reg, ctl_s2_reg;
  logic tick;
  logic [CNT_W-1:0] ap_delay;
  logic [NUM_BANKS-1:0] act_v, pre_v, ap_v, open_w, start_w;
  logic [NUM_BANKS-1:0] open_reg, start_reg;
  logic [CNT_W-1:0] nwr_reg, nrtp_reg;
  bapt_cmd_t cmd;
  logic [2:0] bank;
  logic ap, all_b, bl32;

  // Two-flop synchronisers on every link input; third stage finds the edge.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ck_sync_reg <= '0;
      cmd_s1_reg <= '0;
      cmd_s2_reg <= '0;
      ctl_s1_reg <= '0;
      ctl_s2_reg <= '0;
    end else begin
      ck_sync_reg <= {ck_sync_reg[1:0], link.ck};
      cmd_s1_reg <= link.cmd;
      cmd_s2_reg <= cmd_s1_reg;
      ctl_s1_reg <= {link.bank, link.ap, link.all_banks, link.bl32};
      ctl_s2_reg <= ctl_s1_reg;
    end
  end

  assign tick = ck_sync_reg[1] & ~ck_sync_reg[2];
  assign cmd = bapt_cmd_t'(cmd_s2_reg);
  assign bank = ctl_s2_reg[5:3];
  assign ap = ctl_s2_reg[2];
  assign all_b = ctl_s2_reg[1];
  assign bl32 = ctl_s2_reg[0];

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      nwr_reg <= NWR_RESET;
      nrtp_reg <= NRTP_RESET;
    end else begin
      nwr_reg <= nwr_i;
      nrtp_reg <= nrtp_i;
    end
  end

  // Delay from command to internal precharge, per command kind and burst length.
  always_comb begin
    ap_delay = nrtp_reg;
    if (cmd == BAPT_CMD_RD) begin
      ap_delay = bl32 ? CNT_W'(nrtp_reg + CNT_W'(BL32_EXTRA_NCK)) : nrtp_reg;
    end else begin
      // write AP after burst plus nWR
      ap_delay = CNT_W'(CNT_W'(WL_NCK) + (bl32 ? CNT_W'(BL32 / 2) : CNT_W'(BL16 / 2))
                 + 8'h01 + nwr_reg);
    end
  end

  // Per-bank decode of activate, precharge and auto-precharge requests.
  always_comb begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      act_v[i] = (cmd == BAPT_CMD_ACT) && (bank == 3'(i));
      pre_v[i] = (cmd == BAPT_CMD_PRE) && (all_b || bank == 3'(i));
      ap_v[i] = ap && (bank == 3'(i)) &&
                (cmd == BAPT_CMD_RD || cmd == BAPT_CMD_WR || cmd == BAPT_CMD_MWR);
    end
  end

  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
    bapt_bank u_bank (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .tick_i(tick),
      .act_i(act_v[g]),
      .pre_i(pre_v[g]),
      .ap_i(ap_v[g]),
      .ap_delay_i(ap_delay),
      .open_o(open_w[g]),
      .ap_start_o(start_w[g])
    );
  end

  // Output registers.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      open_reg <= '0;
      start_reg <= '0;
    end else begin
      open_reg <= open_w;
      start_reg <= start_w;
    end
  end

  assign bank_open_o = open_reg;
  assign ap_start_o = start_reg;
endmodule : bapt_dev

// ===== bapt_link_if.sv
// Interface joining the controller end and the device end of the command link.
`timescale 1ns/1ps
interface bapt_link_if;
  logic ck;
  logic [2:0] cmd;
  logic [2:0] bank;
  logic ap;
  logic all_banks;
  logic bl32;
  modport ctrl (output ck, output cmd, output bank, output ap, output all_banks, output bl32);
  modport dev (input ck, input cmd, input bank, input ap, input all_banks, input bl32);
endinterface : bapt_link_if

// ===== bapt_pkg.sv
// Package with command codes and timing constants for bank auto-precharge timing.
package bapt_pkg;
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int CNT_W = 8;
  localparam int CLK_PERIOD_PS = 8000;
  // Link clock divider: half period in system cycles (link period 16 cycles).
  localparam int LINK_HALF_DIV = 8;
  // whole-cycle timing figures
  // Timing figures in link clock cycles (nCK), already rounded up from nanoseconds.
  localparam int T_RCD_NCK = 4;
  localparam int T_RAS_NCK = 10;
  localparam int T_RPPB_NCK = 4;
  localparam int T_RC_NCK = 14;
  localparam int WL_NCK = 4;
  localparam int RL_NCK = 6;
  localparam int T_WTR_NCK = 4;
  localparam int T_RTP_NCK = 4;
  localparam int T_WPRE_NCK = 2;
  localparam int T_RPST_NCK = 1;
  localparam int T_DQSCK_NCK = 1;
  localparam int BL32_EXTRA_NCK = 8;
  localparam int BL16 = 16;
  localparam int BL32 = 32;
  localparam logic [7:0] NWR_RESET = 8'h06;
  localparam logic [7:0] NRTP_RESET = 8'h04;
  // Command codes carried over the link.
  typedef enum logic [2:0] {
    BAPT_CMD_NOP = 3'h0,
    BAPT_CMD_ACT = 3'h1,
    BAPT_CMD_RD = 3'h2,
    BAPT_CMD_WR = 3'h3,
    BAPT_CMD_MWR = 3'h4,
    BAPT_CMD_PRE = 3'h5
  } bapt_cmd_t;
endpackage : bapt_pkg
